// [hdl/apg_defs.vh]
/*
 constants for the peripheral indexed address generator and the
 charge-unit channel enable register.
 assumes plain verilog-2005 consumers; definitions only.
*/
`ifndef APG_DEFS_VH
`define APG_DEFS_VH

// ==========================================================
// register map (byte addresses on the avalon bus)
`define APG_ADDR_W 4
`define APG_REG_CHARGE_UNIT_CHANNEL_ENABLE 4'h0
`define APG_REG_CTRL 4'h4
`define APG_REG_REQ 4'h8
`define APG_REG_OFFS 4'hc

// ==========================================================
// fields and reset values
`define APG_CHARGE_UNIT_CHANNEL_ENABLE_RST 16'h0000
`define APG_CHARGE_UNIT_CHANNEL_ENABLE_IMPL 16'h1eff
`define APG_CHARGE_UNIT_CHANNEL_ENABLE_28PIN 16'h03ff
`define APG_BLC_RST 3'h0
`define APG_OFFS_W 11
`define APG_BLC_LSB 0
`define APG_BLC_MSB 2
`define APG_CH_LSB 0
`define APG_CH_MSB 4
`define APG_IDX_LSB 8
`define APG_IDX_MSB 14
`define APG_MASK_MIN 6

`endif

// [hdl/apg_offset_calc.v]
/*
 combinational offset and base-mask calculation.
 assumes channel and index already captured by the caller.
*/
`timescale 1ns/10ps
`include "apg_defs.vh"

module apg_offset_calc (
   input wire [2:0] blc_in,
   input wire [4:0] chan_in,
   input wire [6:0] index_in,
   output reg [10:0] offset_out,
   output reg [10:0] base_mask_out,
   output reg [5:0] chan_count_out
);

   reg [6:0] idx_mask;
   reg [11:0] shifted;

   always @* begin
      idx_mask = (7'h01 << blc_in) - 7'h01;
      // channel sits just above the index bits; the top is cut at bit 10
      shifted = {7'h00, chan_in} << blc_in;
      // channel above index above zero bit 0
      offset_out = {shifted[9:0], 1'h0} | {3'h0, index_in & idx_mask, 1'h0};
      // channel field is cut at bit 10, shrinking count above 32 words
      if (blc_in == 3'h7) begin
         chan_count_out = 6'h08;
      end else if (blc_in == 3'h6) begin
         chan_count_out = 6'h10;
      end else begin
         chan_count_out = 6'h20;
      end
      // bits the base must hold at zero
      if (blc_in >= 3'h5) begin
         base_mask_out = 11'h7ff;
      end else begin
         base_mask_out = (11'h040 << blc_in) - 11'h001;
      end
   end

endmodule

// [hdl/apg_charge_unit_channel_enable_reg.v]
/*
 charge-unit channel enable register with implemented-bit masking.
 assumes writes come from the bus slave as one-cycle strobes.
*/
`timescale 1ns/10ps
`include "apg_defs.vh"

module apg_charge_unit_channel_enable_reg #(
   parameter PIN28 = 1
) (
   input wire mclk_in,
   input wire rst_in,
   input wire wr_in,
   input wire [15:0] wdata_in,
   output wire [15:0] value_out
);

   reg [15:0] charge_unit_channel_enable_q;
   wire [15:0] impl;

   assign impl = PIN28 ? (`APG_CHARGE_UNIT_CHANNEL_ENABLE_IMPL & `APG_CHARGE_UNIT_CHANNEL_ENABLE_28PIN) :
      `APG_CHARGE_UNIT_CHANNEL_ENABLE_IMPL;
   assign value_out = charge_unit_channel_enable_q;

   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         charge_unit_channel_enable_q <= `APG_CHARGE_UNIT_CHANNEL_ENABLE_RST;
      end else if (wr_in) begin
         charge_unit_channel_enable_q <= wdata_in & impl;
      end
   end

endmodule

// [hdl/apg_top.v]
/*
 peripheral indexed address generator for converter dma, with the
 charge-unit channel enable register, on an avalon-mm slave.
 assumes a single clock, synchronous inputs, and a dma controller that
 keeps its destination base zero in the masked bits.
*/
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "apg_defs.vh"

module apg_top #(
   parameter PIN28 = 1
) (
   input wire mclk_in,
   input wire rst_in,
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output reg avs_waitrequest_out,
   input wire conv_active_in,
   input wire [4:0] conv_chan_in,
   output reg [15:0] charge_unit_connect_out,
   output reg charge_unit_enable_out,
   output reg [10:0] pia_offset_out,
   output reg pia_offset_valid_out
);

   // ==========================================================
   // bus slave: one wait cycle, then answer
   reg busy_q;
   wire acc;
   wire commit;
   wire hit_charge_unit_channel_enable;
   wire hit_ctrl;
   wire hit_req;
   wire lo_en;
   reg [2:0] blc_q;
   reg [4:0] chan_q;
   reg [6:0] idx_q;
   wire [15:0] charge_unit_channel_enable;
   wire [10:0] offs;
   wire [10:0] bmask;
   wire [5:0] ccount;
   reg [31:0] rd_d;

   assign acc = (avs_read_in | avs_write_in) & ~busy_q;
   // writes land only on the edge where waitrequest is seen low
   assign commit = avs_write_in & busy_q;
   assign lo_en = avs_byteenable_in[0] & avs_byteenable_in[1];
   assign hit_charge_unit_channel_enable = commit & lo_en &
      (avs_address_in == `APG_REG_CHARGE_UNIT_CHANNEL_ENABLE);
   assign hit_ctrl = commit & avs_byteenable_in[0] &
      (avs_address_in == `APG_REG_CTRL);
   assign hit_req = commit & lo_en &
      (avs_address_in == `APG_REG_REQ);

   apg_charge_unit_channel_enable_reg #(
      .PIN28(PIN28)
   ) u_charge_unit_channel_enable (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .wr_in(hit_charge_unit_channel_enable),
      .wdata_in(avs_writedata_in[15:0]),
      .value_out(charge_unit_channel_enable)
   );

   apg_offset_calc u_calc (
      .blc_in(blc_q),
      .chan_in(chan_q),
      .index_in(idx_q),
      .offset_out(offs),
      .base_mask_out(bmask),
      .chan_count_out(ccount)
   );

   always @* begin
      if (avs_address_in == `APG_REG_CHARGE_UNIT_CHANNEL_ENABLE) begin
         rd_d = {16'h0000, charge_unit_channel_enable};
      end else if (avs_address_in == `APG_REG_CTRL) begin
         rd_d = {10'h000, ccount, 5'h00, bmask[10:0] == 11'h000, 7'h00,
            blc_q};
         rd_d[26:16] = bmask;
      end else if (avs_address_in == `APG_REG_REQ) begin
         rd_d = {17'h00000, idx_q, 3'h0, chan_q};
      end else if (avs_address_in == `APG_REG_OFFS) begin
         rd_d = {21'h000000, offs};
      end else begin
         rd_d = 32'h00000000;
      end
   end

   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= 1'h0;
         avs_waitrequest_out <= 1'h1;
         avs_readdata_out <= 32'h00000000;
      end else begin
         busy_q <= acc;
         avs_waitrequest_out <= ~acc;
         if (acc & avs_read_in) begin
            avs_readdata_out <= rd_d;
         end
      end
   end

   // ==========================================================
   // address generation state
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         blc_q <= `APG_BLC_RST;
         chan_q <= 5'h00;
         idx_q <= 7'h00;
         pia_offset_out <= 11'h000;
         pia_offset_valid_out <= 1'h0;
      end else begin
         if (hit_ctrl) begin
            blc_q <= avs_writedata_in[`APG_BLC_MSB:`APG_BLC_LSB];
         end
         if (hit_req) begin
            chan_q <= avs_writedata_in[`APG_CH_MSB:`APG_CH_LSB];
            idx_q <= avs_writedata_in[`APG_IDX_MSB:`APG_IDX_LSB];
         end
         pia_offset_out <= offs;
         pia_offset_valid_out <= busy_q & ~avs_waitrequest_out ? 1'h0 :
            1'h1;
      end
   end

   // ==========================================================
   // charge-time unit routing during conversion
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         charge_unit_connect_out <= 16'h0000;
         charge_unit_enable_out <= 1'h0;
      end else begin
         charge_unit_connect_out <= 16'h0000;
         charge_unit_enable_out <= 1'h0;
         if (conv_active_in && charge_unit_channel_enable[conv_chan_in[3:0]] &&
            !conv_chan_in[4]) begin
            charge_unit_connect_out <= 16'h0001 << conv_chan_in[3:0];
            charge_unit_enable_out <= 1'h1;
         end
      end
   end

endmodule

// [sim/apg_dma_model.sv]
/* dma controller model joining base and offset.
 assumes a base with zero masked low bits. */
`timescale 1ns/10ps
module apg_dma_model (
   input wire mclk_in,
   input wire [15:0] base_in,
   input wire [10:0] offset_in,
   input wire valid_in,
   output reg [15:0] addr_out
);
   initial addr_out = 16'h0000;
   always @(posedge mclk_in) begin
      if (valid_in)
         addr_out <= base_in | {5'h00, offset_in};
   end
endmodule

// [sim/apg_top_assertions.sv]
/* checker on apg_top ports.
 assumes one clock, reset high. */
`timescale 1ns/10ps
module apg_chk #(parameter PIN28 = 1) (
   input wire mclk_in,
   input wire rst_in,
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire [31:0] avs_readdata_out,
   input wire avs_waitrequest_out,
   input wire conv_active_in,
   input wire [4:0] conv_chan_in,
   input wire [15:0] charge_unit_connect_out,
   input wire charge_unit_enable_out,
   input wire [10:0] pia_offset_out,
   input wire pia_offset_valid_out
);
   wire [15:0] im = PIN28 ? 16'h02ff : 16'h1eff;
   wire [15:0] cn = charge_unit_connect_out;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // ====================
   // offset lsb, charge-unit routing and enable register answer
   sequence en_rd;
      avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0;
   endsequence
   off_lsb_a: assert property (
      pia_offset_valid_out |-> !pia_offset_out[0]) else $error("lsb");
   one_chan_a: assert property ($onehot0(cn)) else $error("hot");
   idle_off_a: assert property (
      !conv_active_in |=> cn == 16'h0000) else $error("idle");
   chan_route_a: assert property (
      conv_active_in |=> cn == 16'h0 || cn == 16'h1 << $past(conv_chan_in))
      else $error("route");
   route_en_a: assert property (
      |cn |-> charge_unit_enable_out) else $error("en");
   conn_impl_a: assert property ((cn & ~im) == 0) else $error("ci");
   rd_impl_a: assert property (
      en_rd |-> (avs_readdata_out[15:0] & ~im) == 0) else $error("rd");
endmodule
bind apg_top apg_chk #(.PIN28(PIN28)) chk (.mclk_in(mclk_in),
   .rst_in(rst_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .conv_active_in(conv_active_in), .conv_chan_in(conv_chan_in),
   .charge_unit_connect_out(charge_unit_connect_out),
   .charge_unit_enable_out(charge_unit_enable_out),
   .pia_offset_out(pia_offset_out),
   .pia_offset_valid_out(pia_offset_valid_out));

// [sim/testbench.sv]
/* bench for apg_top.
 assumes dma model and checker compiled first. */
`timescale 1ns/10ps
module testbench;
   reg c = 1'b0, rs = 1'b1, rd = 1'b0, wr = 1'b0, ca = 1'b0;
   reg [3:0] a = 4'h0;
   reg [31:0] wd = 32'h0, r;
   reg [4:0] cc = 5'h00;
   wire [31:0] q;
   wire wq, ce, pv;
   wire [15:0] cn, da;
   wire [10:0] po;
   integer n_mismatch = 0, compares = 0, i;
   initial forever #50 c = ~c;
   apg_top #(.PIN28(1)) dut (.mclk_in(c), .rst_in(rs),
      .avs_address_in(a), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
      .avs_readdata_out(q), .avs_waitrequest_out(wq),
      .conv_active_in(ca), .conv_chan_in(cc),
      .charge_unit_connect_out(cn), .charge_unit_enable_out(ce),
      .pia_offset_out(po), .pia_offset_valid_out(pv));
   apg_dma_model dma (.mclk_in(c), .base_in(16'hf800),
      .offset_in(po), .valid_in(pv), .addr_out(da));
   // ====================
   task final_report;
      begin
         $display("compares %0d n_mismatch %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // request held until waitrequest seen low
   task bus(input w, input [3:0] ad, input [31:0] d);
      integer k;
      begin
         a <= ad;
         wd <= d;
         wr <= w;
         rd <= !w;
         k = 0;
         @(posedge c);
         while (wq !== 1'b0 && k < 40) begin
            k = k + 1;
            @(posedge c);
         end
         r = q;
         wr <= 1'b0;
         rd <= 1'b0;
         @(posedge c);
         if (k == 40) begin
            n_mismatch = n_mismatch + 1;
            final_report;
         end
      end
   endtask
   function [31:0] eo(input [31:0] n);
      eo = ((32'h1b << n | 32'h55 & ((32'h1 << n) - 1)) << 1) & 32'h7ff;
   endfunction
   // ====================
   task t_regs;
      begin
         bus(0, 4'h0, 0);
         chk(r, 0);
         bus(1, 4'h0, 32'hffff);
         bus(0, 4'h0, 0);
         chk(r, 32'h02ff);
         bus(0, 4'h2, 0);
         chk(r, 0);
         $display("regs done");
      end
   endtask
   task t_codes;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            bus(1, 4'h4, i);
            bus(1, 4'h8, 32'h551b);
            bus(0, 4'hc, 0);
            chk(r, eo(i));
            chk(po, eo(i));
            chk(da, 32'hf800 | eo(i));
            bus(0, 4'h4, 0);
            chk(r[2:0], i);
            chk(r[26:16], (32'h1 << (i > 5 ? 11 : i + 6)) - 1);
         end
         $display("codes done");
      end
   endtask
   task cv(input act, input [4:0] ch, input [15:0] e);
      begin
         ca <= act;
         cc <= ch;
         repeat (3) @(posedge c);
         chk(cn, e);
         chk(ce, e != 0);
      end
   endtask
   task t_conv;
      begin
         bus(1, 4'h0, 32'h1409);
         cv(1, 3, 16'h0008);
         cv(1, 1, 0);
         cv(1, 10, 0);
         cv(1, 0, 16'h0001);
         cv(0, 0, 0);
         $display("conv done");
      end
   endtask
   initial begin
      repeat (6) @(posedge c);
      rs <= 1'b0;
      @(posedge c);
      t_regs;
      t_codes;
      t_conv;
      final_report;
   end
endmodule
